// File: shared/csc_regs.svh
// constants for the chip-select controller: field positions, resets, codes
`ifndef CSC_REGS_SVH
`define CSC_REGS_SVH

// ----------------------------------------------------------------------
// control word fields (chip-select and fallback memory)
// ----------------------------------------------------------------------
`define CSC_CTL_W        15
`define CSC_CTL_RD       0
`define CSC_CTL_WR       1
`define CSC_CTL_RDHOLD   2
`define CSC_CTL_WRHOLD   3
`define CSC_CTL_SETUP    4
`define CSC_CTL_BURST    5
`define CSC_CTL_PW_LO    6
`define CSC_CTL_PW_HI    7
`define CSC_CTL_INTTERM  8
`define CSC_CTL_BCONT    9
`define CSC_CTL_WS_LO    10
`define CSC_CTL_WS_HI    13
`define CSC_CTL_ALTACK   14

// ----------------------------------------------------------------------
// mask word fields
// ----------------------------------------------------------------------
`define CSC_MSK_W        21
`define CSC_MSK_UD       0
`define CSC_MSK_UC       1
`define CSC_MSK_SD       2
`define CSC_MSK_SC       3
`define CSC_MSK_CPU      4
`define CSC_MSK_IGN_LO   5
`define CSC_MSK_IGN_HI   20

// ----------------------------------------------------------------------
// reset values and counts
// ----------------------------------------------------------------------
`define CSC_CS0_CTL_RST  15'h3C1F
`define CSC_CS0_MSK_RST  21'h00_0000
`define CSC_WS_MAX       4'hF
`define CSC_LANES_8      4'h8
`define CSC_LANES_16     4'hC
`define CSC_LANES_32     4'hF

`endif

// File: shared/csc_pkg.sv
// types shared by the chip-select controller modules
package csc_pkg;

	// ------------------------------------------------------------------
	// port width codes, bank kinds and bus states
	// ------------------------------------------------------------------
	typedef enum logic [1:0] {
		CSC_PW_32 = 2'h0,
		CSC_PW_8  = 2'h1,
		CSC_PW_16 = 2'h2
	} csc_width_t;

	typedef enum logic [1:0] {
		CSC_KIND_CS,
		CSC_KIND_DRAM,
		CSC_KIND_DEFAULT
	} csc_kind_t;

	typedef enum logic [1:0] {
		CSC_IDLE,
		CSC_ACCESS,
		CSC_HOLD
	} csc_state_t;

endpackage

// File: hdl/csc_bank_match.sv
// address compare of one bank against its base and ignore mask
`timescale 1ns/100ps
module csc_bank_match (
	// transfer address, upper half
	input  wire logic [15:0] addr_hi,
	// bank setup
	input  wire logic [15:0] base,
	input  wire logic [15:0] ignore,
	// result
	output logic             hit
);
	assign hit = ((addr_hi ^ base) & ~ignore) == 16'h0000; // RULE22
endmodule

// File: hdl/csc_ack_sync.sv
// two-stage synchroniser for the asynchronous acknowledge pin
`timescale 1ns/100ps
module csc_ack_sync (
	// clock and reset
	input  wire logic ref_clk,
	input  wire logic resetn,
	// pin and synchronised level
	input  wire logic ack_async_n,
	output logic      ack_sync
);
	logic meta_reg;
	logic meta_next;
	logic sync_reg;
	logic sync_next;

	always_comb begin
		meta_next = ~ack_async_n;
		sync_next = meta_reg;
	end

	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			meta_reg <= 1'b0;
			sync_reg <= 1'b0;
		end else begin
			meta_reg <= meta_next;
			sync_reg <= sync_next;
		end
	end

	assign ack_sync = sync_reg; // RULE10
endmodule

// File: hdl/csc_chip_select.sv
// chip-select controller: decode, permissions, wait states, strobes
`timescale 1ns/100ps
`include "csc_regs.svh"

// Notes on behaviour
// [RULE1] banks zero to seven, then dram zero and one; lowest number wins
// [RULE2] no hit: fallback settings used, no select or dram output asserted
// [RULE3] each select has its own read and write enable bits
// [RULE4] attribute masks per select; only select one may mask cpu space
// [RULE5] select asserts only on address hit, enabled direction, unmasked
// [RULE6] port widths 8, 16, 32 bits on top lane, top half, full bus
// [RULE7] wait count zero to fifteen; internal termination ends after count
// [RULE8] core transfer: early synchronous acknowledge ends it that cycle
// [RULE9] alternate master with internal termination: we drive acknowledge
// [RULE10] async acknowledge is synchronised and ends the access at once
// [RULE11] outside party may end alternate master access by async ack
// [RULE12] burst when operand wider than port and burst bit set, else split
// [RULE13] setup option: select in start cycle or one cycle later
// [RULE14] burst option: select held continuously across beats or not
// [RULE15] hold option keeps address, attributes, write data one more cycle
// [RULE16] after reset select zero hits all but cpu space and internal
// [RULE17] select zero width and auto ack come from straps at reset
// [RULE18] select zero resets with rd, wr, setup, holds on, burst off
// [RULE19] writing select zero control keeps global mode active
// [RULE20] first write to select zero mask ends global mode until reset
// [RULE21] software sets up all banks before writing select zero mask
// [RULE22] address bits 31 to 16 compared to base, ignoring masked bits
// [RULE23] write enables assert the cycle after the select asserts
// [RULE24] without internal termination, wait until an acknowledge is seen
module csc_chip_select
	import csc_pkg::*;
(
	// clock and reset
	input  wire logic                      ref_clk,
	input  wire logic                      resetn,
	// transfer request
	input  wire logic                      transfer_start,
	input  wire logic [31:0]               xfer_addr,
	input  wire logic                      xfer_write,
	input  wire logic [1:0]                xfer_size,
	input  wire logic                      xfer_super,
	input  wire logic                      xfer_code,
	input  wire logic                      xfer_cpu_space,
	input  wire logic                      xfer_internal,
	input  wire logic                      xfer_alt_master,
	// bank setup
	input  wire logic [7:0][15:0]          select_base_register,
	input  wire logic [7:1][20:0]          select_mask_register,
	input  wire logic [7:1][14:0]          select_control_register,
	input  wire logic [1:0][15:0]          dram_bank_address_register,
	input  wire logic [1:0][15:0]          dram_bank_mask_register,
	input  wire logic [14:0]               fallback_memory_control,
	// select zero writes
	input  wire logic [14:0]               cs0_ctrl_wdata,
	input  wire logic                      cs0_ctrl_write,
	input  wire logic [20:0]               cs0_mask_wdata,
	input  wire logic                      cs0_mask_write,
	// boot straps
	input  wire logic                      boot_strap_pin_one,
	input  wire logic                      boot_strap_pin_four,
	input  wire logic                      boot_strap_pin_seven,
	// acknowledges
	input  wire logic                      transfer_acknowledge_n_in,
	output logic                           transfer_acknowledge_n_out,
	output logic                           transfer_acknowledge_oe,
	input  wire logic                      async_transfer_ack_n,
	// bus strobes and status
	output logic [7:0]                     chip_select_n,
	output logic [1:0]                     dram_bank_hit,
	output logic [3:0]                     write_enable_n,
	output logic                           xfer_done,
	output logic                           burst_active,
	output logic [1:0]                     port_width_out,
	output logic                           addr_hold,
	output logic                           global_mode
);
	// ------------------------------------------------------------------
	// select zero registers and straps
	// ------------------------------------------------------------------
	logic [2:0]  strap_reg;
	logic [2:0]  strap_next;
	logic [14:0] cs0_ctl_reg;
	logic [14:0] cs0_ctl_next;
	logic [20:0] cs0_msk_reg;
	logic [20:0] cs0_msk_next;
	logic        global_reg;
	logic        global_next;
	logic        cs0_written_reg;
	logic        cs0_written_next;

	// straps are caught by a plain clocked flop: the last edge in reset wins
	always_comb begin
		strap_next = strap_reg;
		if (!resetn)
			strap_next = {boot_strap_pin_seven, boot_strap_pin_four,
				boot_strap_pin_one}; // RULE17
	end

	always_ff @(posedge ref_clk) begin
		strap_reg <= strap_next;
	end

	always_comb begin
		cs0_ctl_next     = cs0_ctl_reg;
		cs0_msk_next     = cs0_msk_reg;
		global_next      = global_reg;
		cs0_written_next = cs0_written_reg;
		if (cs0_ctrl_write) begin
			cs0_ctl_next     = cs0_ctrl_wdata; // RULE19
			cs0_written_next = 1'b1;
		end
		if (cs0_mask_write) begin
			cs0_msk_next = cs0_mask_wdata;
			global_next  = 1'b0; // RULE20
		end
	end

	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			cs0_ctl_reg     <= `CSC_CS0_CTL_RST; // RULE18
			cs0_msk_reg     <= `CSC_CS0_MSK_RST;
			global_reg      <= 1'b1;
			cs0_written_reg <= 1'b0;
		end else begin
			cs0_ctl_reg     <= cs0_ctl_next;
			cs0_msk_reg     <= cs0_msk_next;
			global_reg      <= global_next;
			cs0_written_reg <= cs0_written_next;
		end
	end

	// ------------------------------------------------------------------
	// effective bank words and address compare
	// ------------------------------------------------------------------
	logic [7:0][14:0] ctl_eff;
	logic [7:0][20:0] msk_eff;
	logic [9:0]       addr_hit;
	logic [7:0]       cs_ok;

	// width and auto ack follow the straps until software rewrites them
	always_comb begin
		ctl_eff[0] = cs0_ctl_reg;
		if (!cs0_written_reg) begin
			ctl_eff[0][`CSC_CTL_PW_HI:`CSC_CTL_PW_LO] = strap_reg[2:1];
			ctl_eff[0][`CSC_CTL_INTTERM]             = strap_reg[0];
		end
		msk_eff[0] = cs0_msk_reg;
		for (int k = 1; k < 8; k++) begin
			ctl_eff[k] = select_control_register[k];
			msk_eff[k] = select_mask_register[k];
		end
	end

	genvar g;
	generate
		for (g = 0; g < 10; g++) begin : g_bank
			if (g < 8) begin : g_cs
				logic dir_ok;
				logic attr_ok;
				logic cpu_ok;
				csc_bank_match u_match (
					.addr_hi (xfer_addr[31:16]),
					.base    (select_base_register[g]),
					.ignore  (msk_eff[g][`CSC_MSK_IGN_HI:`CSC_MSK_IGN_LO]),
					.hit     (addr_hit[g])
				);
				assign dir_ok = xfer_write ? ctl_eff[g][`CSC_CTL_WR] :
					ctl_eff[g][`CSC_CTL_RD]; // RULE3
				assign cpu_ok = (g != 1) || !xfer_cpu_space ||
					!msk_eff[g][`CSC_MSK_CPU]; // RULE4
				assign attr_ok = cpu_ok && !(xfer_super ?
					(xfer_code ? msk_eff[g][`CSC_MSK_SC] :
						msk_eff[g][`CSC_MSK_SD]) :
					(xfer_code ? msk_eff[g][`CSC_MSK_UC] :
						msk_eff[g][`CSC_MSK_UD])); // RULE4
				if (g == 0) begin : g_global
					assign cs_ok[g] = global_reg ?
						(dir_ok && !xfer_cpu_space) : // RULE16
						(addr_hit[g] && dir_ok && attr_ok); // RULE5
				end else begin : g_plain
					assign cs_ok[g] = addr_hit[g] && dir_ok && attr_ok; // RULE5
				end
			end else begin : g_dram
				csc_bank_match u_match (
					.addr_hi (xfer_addr[31:16]),
					.base    (dram_bank_address_register[g-8]),
					.ignore  (dram_bank_mask_register[g-8]),
					.hit     (addr_hit[g])
				);
			end
		end
	endgenerate

	// ------------------------------------------------------------------
	// priority pick of the bank for a new transfer
	// ------------------------------------------------------------------
	csc_kind_t   pick_kind;
	logic [2:0]  pick_idx;
	logic [14:0] pick_ctl;
	logic        pick_found;

	always_comb begin
		pick_kind  = CSC_KIND_DEFAULT; // RULE2
		pick_idx   = 3'h0;
		pick_found = 1'b0;
		for (int k = 0; k < 8; k++) begin
			if (cs_ok[k] && !pick_found) begin // RULE1
				pick_found = 1'b1;
				pick_kind  = CSC_KIND_CS;
				pick_idx   = k[2:0];
			end
		end
		for (int k = 0; k < 2; k++) begin
			if (addr_hit[8+k] && !pick_found) begin // RULE1
				pick_found = 1'b1;
				pick_kind  = CSC_KIND_DRAM;
				pick_idx   = k[2:0];
			end
		end
		pick_ctl = (pick_kind == CSC_KIND_CS) ? ctl_eff[pick_idx] :
			fallback_memory_control; // RULE2
	end

	// ------------------------------------------------------------------
	// access sequencer
	// ------------------------------------------------------------------
	csc_state_t  state_reg,   state_next;
	csc_kind_t   kind_reg,    kind_next;
	logic [2:0]  idx_reg,     idx_next;
	logic [14:0] ctl_reg,     ctl_next;
	logic        write_reg,   write_next;
	logic        alt_reg,     alt_next;
	logic [3:0]  cnt_reg,     cnt_next;
	logic [3:0]  beats_reg,   beats_next;
	logic        first_reg,   first_next;
	logic        burst_reg,   burst_next;
	logic        ack_async;
	logic        accessing;
	logic        int_term;
	logic        ta_drive;
	logic        ends;
	logic [2:0]  op_lg;
	logic [2:0]  pw_lg;
	logic [2:0]  lg_diff;

	csc_ack_sync u_ack_sync (
		.ref_clk     (ref_clk),
		.resetn      (resetn),
		.ack_async_n (async_transfer_ack_n),
		.ack_sync    (ack_async)
	);

	assign accessing = state_reg == CSC_ACCESS;
	assign int_term  = ctl_reg[`CSC_CTL_INTTERM] &&
		(!alt_reg || ctl_reg[`CSC_CTL_ALTACK]);
	assign ta_drive  = accessing && alt_reg && int_term &&
		kind_reg != CSC_KIND_DRAM; // RULE9
	// wait count, early sync ack, or early async ack; otherwise wait on
	assign ends = accessing && (
		(int_term && kind_reg != CSC_KIND_DRAM &&
			cnt_reg == ctl_reg[`CSC_CTL_WS_HI:`CSC_CTL_WS_LO]) || // RULE7
		(!ta_drive && !transfer_acknowledge_n_in) || // RULE8 RULE24
		(ack_async && kind_reg != CSC_KIND_DRAM)); // RULE10 RULE11

	always_comb begin
		case (xfer_size)
			2'h1:    op_lg = 3'h0;
			2'h2:    op_lg = 3'h1;
			2'h3:    op_lg = 3'h4;
			default: op_lg = 3'h2;
		endcase
		case (pick_ctl[`CSC_CTL_PW_HI:`CSC_CTL_PW_LO])
			CSC_PW_8:  pw_lg = 3'h0;
			CSC_PW_16: pw_lg = 3'h1;
			default:   pw_lg = 3'h2;
		endcase
		lg_diff = (op_lg > pw_lg) ? op_lg - pw_lg : 3'h0;
	end

	always_comb begin
		state_next = state_reg;
		kind_next  = kind_reg;
		idx_next   = idx_reg;
		ctl_next   = ctl_reg;
		write_next = write_reg;
		alt_next   = alt_reg;
		cnt_next   = cnt_reg;
		beats_next = beats_reg;
		first_next = first_reg;
		burst_next = burst_reg;
		case (state_reg)
			CSC_IDLE: begin
				// a start while busy is not seen; the master waits for done
				if (transfer_start && !xfer_internal) begin
					state_next = CSC_ACCESS;
					kind_next  = pick_kind;
					idx_next   = pick_idx;
					ctl_next   = pick_ctl;
					write_next = xfer_write;
					alt_next   = xfer_alt_master;
					cnt_next   = 4'h0;
					first_next = 1'b1;
					// the master splits when bursts are off
					burst_next = pick_ctl[`CSC_CTL_BURST] &&
						lg_diff != 3'h0; // RULE12
					beats_next = burst_next ?
						4'((5'h01 << lg_diff) - 5'h01) : 4'h0; // RULE12
				end
			end
			CSC_ACCESS: begin
				if (cnt_reg != `CSC_WS_MAX)
					cnt_next = cnt_reg + 4'h1;
				if (ends) begin
					if (beats_reg != 4'h0) begin
						beats_next = beats_reg - 4'h1;
						cnt_next   = 4'h0;
						first_next = 1'b0;
					end else if (kind_reg != CSC_KIND_DRAM &&
						(write_reg ? ctl_reg[`CSC_CTL_WRHOLD] :
							ctl_reg[`CSC_CTL_RDHOLD])) begin
						state_next = CSC_HOLD; // RULE15
					end else begin
						state_next = CSC_IDLE;
					end
				end
			end
			CSC_HOLD: begin
				state_next = CSC_IDLE;
			end
			default: begin
				state_next = CSC_IDLE;
			end
		endcase
	end

	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			state_reg <= CSC_IDLE;
			kind_reg  <= CSC_KIND_DEFAULT;
			idx_reg   <= 3'h0;
			ctl_reg   <= 15'h0000;
			write_reg <= 1'b0;
			alt_reg   <= 1'b0;
			cnt_reg   <= 4'h0;
			beats_reg <= 4'h0;
			first_reg <= 1'b0;
			burst_reg <= 1'b0;
		end else begin
			state_reg <= state_next;
			kind_reg  <= kind_next;
			idx_reg   <= idx_next;
			ctl_reg   <= ctl_next;
			write_reg <= write_next;
			alt_reg   <= alt_next;
			cnt_reg   <= cnt_next;
			beats_reg <= beats_next;
			first_reg <= first_next;
			burst_reg <= burst_next;
		end
	end

	// ------------------------------------------------------------------
	// strobes
	// ------------------------------------------------------------------
	logic       cs_gap;
	logic       cs_on;
	logic       cs_early;
	logic [1:0] we_delay;
	logic [3:0] lanes;

	// a non-continuous burst drops the select for one cycle per new beat
	assign cs_gap = !first_reg && !ctl_reg[`CSC_CTL_BCONT] &&
		cnt_reg == 4'h0; // RULE14
	assign cs_on = accessing && kind_reg == CSC_KIND_CS && !cs_gap;
	assign cs_early = state_reg == CSC_IDLE && transfer_start &&
		!xfer_internal && pick_kind == CSC_KIND_CS &&
		!pick_ctl[`CSC_CTL_SETUP]; // RULE13
	assign we_delay = first_reg ? {1'b0, ctl_reg[`CSC_CTL_SETUP]} :
		{!ctl_reg[`CSC_CTL_BCONT], 1'b0}; // RULE23

	always_comb begin
		case (ctl_reg[`CSC_CTL_PW_HI:`CSC_CTL_PW_LO])
			CSC_PW_8:  lanes = `CSC_LANES_8; // RULE6
			CSC_PW_16: lanes = `CSC_LANES_16; // RULE6
			default:   lanes = `CSC_LANES_32; // RULE6
		endcase
		for (int k = 0; k < 8; k++)
			chip_select_n[k] = !((cs_on && idx_reg == k[2:0]) ||
				(cs_early && pick_idx == k[2:0])); // RULE5 RULE13
		for (int k = 0; k < 2; k++)
			dram_bank_hit[k] = accessing && kind_reg == CSC_KIND_DRAM &&
				idx_reg == k[2:0];
		write_enable_n = ~(lanes & {4{cs_on && write_reg &&
			cnt_reg >= {2'h0, we_delay}}}); // RULE23
	end

	assign transfer_acknowledge_oe    = ta_drive; // RULE9
	assign transfer_acknowledge_n_out = !(ta_drive && ends);
	assign xfer_done      = ends;
	assign burst_active   = burst_reg;
	assign port_width_out = ctl_reg[`CSC_CTL_PW_HI:`CSC_CTL_PW_LO];
	assign addr_hold      = state_reg == CSC_HOLD; // RULE15
	assign global_mode    = global_reg;
endmodule

// File: tb/csc_chip_select_asserts.sv
// concurrent checks on the chip-select controller ports
`timescale 1ns/100ps
module csc_chip_select_asserts (
	// clock and reset
	input wire logic       ref_clk,
	input wire logic       resetn,
	// requests and pins
	input wire logic       transfer_start,
	input wire logic       cs0_mask_write,
	input wire logic       transfer_acknowledge_n_in,
	input wire logic       async_transfer_ack_n,
	// outputs
	input wire logic       transfer_acknowledge_n_out,
	input wire logic       transfer_acknowledge_oe,
	input wire logic [7:0] chip_select_n,
	input wire logic [1:0] dram_bank_hit,
	input wire logic [3:0] write_enable_n,
	input wire logic       xfer_done,
	input wire logic       addr_hold,
	input wire logic       global_mode
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!resetn);

	a_one_select:
		assert property ($onehot0(~chip_select_n))
		else $error("two selects asserted together");
	a_dram_alone:
		assert property (dram_bank_hit != 2'h0 |->
			chip_select_n == 8'hFF && $onehot(dram_bank_hit))
		else $error("dram hit beside a select");
	a_we_after_select:
		assert property (write_enable_n != 4'hF |->
			$past(chip_select_n) != 8'hFF)
		else $error("write enable without select one cycle before");
	a_mask_ends_global:
		assert property (cs0_mask_write |=> !global_mode)
		else $error("global mode kept after mask write");
	a_global_stays_off:
		assert property (!global_mode |=> !global_mode)
		else $error("global mode came back without reset");
	a_hold_after_done:
		assert property (addr_hold |-> $past(xfer_done) &&
			chip_select_n == 8'hFF && write_enable_n == 4'hF)
		else $error("hold cycle not right after termination");
	a_driven_ack_done:
		assert property (transfer_acknowledge_oe && !xfer_done |->
			transfer_acknowledge_n_out ##1 transfer_acknowledge_oe)
		else $error("driven acknowledge early or released");
	a_sync_ack_ends:
		assert property (!transfer_acknowledge_n_in && !transfer_acknowledge_oe
			&& chip_select_n != 8'hFF && !transfer_start |-> xfer_done)
		else $error("acknowledge seen but access not ended");
	a_async_ack_ends:
		assert property ((!async_transfer_ack_n)[*3] ##0
			(chip_select_n != 8'hFF && !transfer_start) |-> xfer_done)
		else $error("synchronised async acknowledge ignored");

	c_hold: cover property (addr_hold);
	c_alt_ack: cover property (transfer_acknowledge_oe && xfer_done);
	c_dram: cover property (dram_bank_hit != 2'h0 && xfer_done);
endmodule

bind csc_chip_select csc_chip_select_asserts u_chk (.ref_clk, .resetn,
	.transfer_start, .cs0_mask_write, .transfer_acknowledge_n_in,
	.async_transfer_ack_n, .transfer_acknowledge_n_out,
	.transfer_acknowledge_oe, .chip_select_n, .dram_bank_hit,
	.write_enable_n, .xfer_done, .addr_hold, .global_mode);

// File: tb/csc_mem_model.sv
// far-side memory model: silent, synchronous or asynchronous acknowledge
`timescale 1ns/100ps
module csc_mem_model (
	// clock and reset
	input  wire logic       ref_clk,
	input  wire logic       resetn,
	// bus view
	input  wire logic       sel,
	input  wire logic       ta_oe,
	// 0 silent, 1 sync ack, 2 async ack; answer after lat selected cycles
	input  wire logic [1:0] mode,
	input  wire logic [3:0] lat,
	// acknowledge pins
	output logic            ta_drv,
	output logic            ta_n,
	output logic            ata_n
);
	logic [3:0] cnt_reg;
	logic [3:0] cnt_next;

	always_comb cnt_next = !sel ? 4'h0 :
		cnt_reg == 4'hF ? cnt_reg : cnt_reg + 4'h1;

	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn)
			cnt_reg <= 4'h0;
		else
			cnt_reg <= cnt_next;
	end

	// never fight the controller while it owns the pin
	assign ta_drv = sel && mode == 2'h1 && !ta_oe;
	assign ta_n = cnt_reg != lat;
	// held low until the select drops, so the synchroniser surely sees it
	assign ata_n = !(sel && mode == 2'h2 && cnt_reg >= lat);
endmodule

// File: tb/test_csc_chip_select.sv
// self-checking bench for the chip-select controller
`timescale 1ns/100ps
`include "csc_regs.svh"
module test_csc_chip_select;
	import csc_pkg::*;
	typedef struct {logic [9:0] sel; int lat;} csc_exp_t;
	logic             ref_clk = 0, resetn = 0, transfer_start = 0;
	logic             xfer_write = 0, xfer_super = 0, xfer_code = 0;
	logic             xfer_cpu_space = 0, xfer_internal = 0, xfer_alt_master = 0;
	logic             cs0_ctrl_write = 0, cs0_mask_write = 0;
	logic             ta_drv, ta_n, async_transfer_ack_n, xfer_done;
	logic             transfer_acknowledge_n_out, transfer_acknowledge_oe;
	logic             burst_active, addr_hold, global_mode;
	logic [31:0]      xfer_addr = 0;
	logic [7:0][15:0] select_base_register;
	logic [7:1][20:0] select_mask_register = '0;
	logic [7:1][14:0] select_control_register;
	logic [1:0][15:0] dram_bank_address_register, dram_bank_mask_register;
	logic [14:0]      fallback_memory_control, cs0_ctrl_wdata;
	logic [20:0]      cs0_mask_wdata = 0;
	logic [7:0]       chip_select_n;
	logic [1:0]       dram_bank_hit, port_width_out, mode = 0;
	logic [3:0]       write_enable_n, lat = 0;
	logic [15:0]      hi;
	logic [9:0]       x;
	csc_exp_t         exp_q[$], e;
	int               errors = 0, n_tests = 0, cyc = 0, k;
	wire transfer_acknowledge_n_in = transfer_acknowledge_oe ?
		transfer_acknowledge_n_out : (ta_drv ? ta_n : 1'b1);

	csc_chip_select dut (.ref_clk, .resetn, .transfer_start, .xfer_addr,
		.xfer_write, .xfer_size(2'h0), .xfer_super, .xfer_code, .xfer_cpu_space,
		.xfer_internal, .xfer_alt_master, .select_base_register,
		.select_mask_register, .select_control_register,
		.dram_bank_address_register, .dram_bank_mask_register,
		.fallback_memory_control, .cs0_ctrl_wdata, .cs0_ctrl_write,
		.cs0_mask_wdata, .cs0_mask_write, .boot_strap_pin_one(1'b1),
		.boot_strap_pin_four(1'b0), .boot_strap_pin_seven(1'b0),
		.transfer_acknowledge_n_in, .transfer_acknowledge_n_out,
		.transfer_acknowledge_oe, .async_transfer_ack_n, .chip_select_n,
		.dram_bank_hit, .write_enable_n, .xfer_done, .burst_active,
		.port_width_out, .addr_hold, .global_mode);
	csc_mem_model mem (.ref_clk, .resetn, .ta_oe(transfer_acknowledge_oe),
		.sel(chip_select_n != 8'hFF || dram_bank_hit != 2'h0), .mode, .lat,
		.ta_drv, .ta_n, .ata_n(async_transfer_ack_n));

	always #4 ref_clk = ~ref_clk;

	// ------------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------------
	function automatic logic [14:0] ctl(input logic [3:0] ws, input logic su,
		input logic ho, input logic te);
		ctl = 15'h4003; // rd, wr, alternate master acknowledge
		ctl[`CSC_CTL_WS_HI:`CSC_CTL_WS_LO] = ws;
		ctl[`CSC_CTL_SETUP] = su;
		ctl[`CSC_CTL_WRHOLD] = ho;
		ctl[`CSC_CTL_INTTERM] = te;
	endfunction

	task cmp_sel(input logic [9:0] x, input logic [9:0] a);
		n_tests++;
		if (a !== x) begin
			errors++;
			$display("[FAIL] %0t select exp %h got %h", $time, x, a);
		end
	endtask

	task cmp_lat(input int x, input int a);
		n_tests++;
		if (a !== x) begin
			errors++;
			$display("[FAIL] %0t cycles exp %h got %h", $time, x, a);
		end
	endtask

	task automatic pulse(ref logic p);
		@(posedge ref_clk);
		#1;
		p = 1;
		@(posedge ref_clk);
		#1;
		p = 0;
	endtask

	// attributes {write, super, code, cpu space, alternate master}
	task xfer(input logic [31:0] a, input logic [4:0] at, input logic in,
		input logic [9:0] s, input int l);
		int n;
		if (!in)
			exp_q.push_back(csc_exp_t'{s, l});
		@(posedge ref_clk);
		#1;
		{xfer_write, xfer_super, xfer_code, xfer_cpu_space, xfer_alt_master} = at;
		xfer_addr = a;
		xfer_internal = in;
		transfer_start = 1;
		@(posedge ref_clk);
		#1;
		transfer_start = 0;
		n = 0;
		while (exp_q.size() != 0 && n < 100) begin
			@(posedge ref_clk);
			n++;
		end
		// gap lets hold cycles and the synchronised ack drain
		repeat (6) @(posedge ref_clk);
		#1;
	endtask

	task finish_test();
		$display("comparisons %0d mismatches %0d", n_tests, errors);
		if (errors == 0 && n_tests > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	// ------------------------------------------------------------------
	// result watcher
	// ------------------------------------------------------------------
	always @(posedge ref_clk) begin
		cyc = (transfer_start && !xfer_internal) ? 0 : cyc + 1;
		if (resetn && xfer_done === 1'b1) begin
			if (exp_q.size() != 0)
				e = exp_q.pop_front();
			else
				e = '{10'h000, -1};
			cmp_sel(e.sel, {dram_bank_hit, chip_select_n});
			cmp_sel(10'h000, {7'h0, burst_active, port_width_out});
			if (e.lat >= 0)
				cmp_lat(e.lat, cyc);
		end
	end

	initial begin
		repeat (5000) @(posedge ref_clk);
		errors++;
		finish_test();
	end

	// ------------------------------------------------------------------
	// stimulus
	// ------------------------------------------------------------------
	initial begin
		void'($urandom(32'ha1d9_d136));
		for (int i = 0; i < 8; i++)
			select_base_register[i] = 16'h1000 + 16'(i);
		for (int i = 1; i < 8; i++)
			select_control_register[i] = ctl(4'hF, 0, 0, 1);
		dram_bank_address_register = {16'h2001, 16'h2000};
		dram_bank_mask_register = {16'h0000, 16'h3001};
		fallback_memory_control = ctl(4'h0, 0, 0, 1);
		cs0_ctrl_wdata = ctl(4'h3, 0, 0, 1);
		select_mask_register[3][`CSC_MSK_IGN_HI:`CSC_MSK_IGN_LO] = 16'h0004;
		repeat (6) @(posedge ref_clk);
		#1;
		resetn = 1;
		mode = 2'h1;
		lat = 4'h2;
		xfer(32'h7777_0000, 5'h10, 0, 10'h0FE, 3);
		xfer(32'h1002_0000, 5'h00, 0, 10'h0FE, 3);
		xfer(32'h7777_0000, 5'h0A, 0, 10'h0FF, 1);
		xfer(32'h7777_0000, 5'h00, 1, 10'h000, -1);
		$display("test global done");
		mode = 2'h0;
		pulse(cs0_ctrl_write);
		xfer(32'h7777_0000, 5'h10, 0, 10'h0FE, 4);
		pulse(cs0_mask_write);
		xfer(32'h7777_0000, 5'h10, 0, 10'h0FF, 1);
		xfer(32'h1000_0000, 5'h10, 0, 10'h0FE, 4);
		for (int w = 0; w < 16; w++) begin
			select_control_register[2] = ctl(w[3:0], 0, 0, 1);
			xfer({16'h1002, 16'($urandom)}, {1'($urandom), 3'h4, w[0]}, 0,
				10'h0FB, w + 1);
		end
		$display("test waits done");
		mode = 2'h1;
		lat = 4'h1;
		for (int i = 0; i < 24; i++) begin
			k = $urandom % 11;
			hi = k < 8 ? 16'h1000 + 16'(k) : k < 10 ? 16'h2000 :
				16'h8000 | 16'($urandom);
			x = k == 7 ? 10'h0F7 : k < 8 ? {2'h0, ~(8'h01 << k)} :
				k == 10 ? 10'h0FF : 10'h1FF;
			xfer({hi, 16'($urandom)}, {3'($urandom), 2'h0}, 0, x, -1);
		end
		$display("test priority done");
		select_control_register[4][`CSC_CTL_WR] = 0;
		select_mask_register[4][`CSC_MSK_UD] = 1;
		select_mask_register[1][`CSC_MSK_CPU] = 1;
		select_mask_register[2][`CSC_MSK_CPU] = 1;
		xfer(32'h1004_0000, 5'h18, 0, 10'h0FF, -1);
		xfer(32'h1004_0000, 5'h00, 0, 10'h0FF, -1);
		xfer(32'h1004_0000, 5'h08, 0, 10'h0EF, -1);
		xfer(32'h1001_0000, 5'h0A, 0, 10'h1FF, -1);
		xfer(32'h1002_0000, 5'h0A, 0, 10'h0FB, -1);
		$display("test permissions done");
		select_control_register[6] = ctl(4'hF, 0, 0, 0);
		lat = 4'h4;
		xfer(32'h1006_0000, 5'h08, 0, 10'h0BF, 4);
		select_control_register[6] = ctl(4'hF, 0, 0, 1);
		lat = 4'h2;
		xfer(32'h1006_0000, 5'h18, 0, 10'h0BF, 2);
		mode = 2'h2;
		lat = 4'h1;
		xfer(32'h1006_0000, 5'h08, 0, 10'h0BF, 3);
		mode = 2'h0;
		select_control_register[5] = ctl(4'h1, 1, 1, 1);
		xfer(32'h1005_0000, 5'h18, 0, 10'h0DF, 2);
		$display("test termination done");
		cmp_lat(0, exp_q.size());
		finish_test();
	end
endmodule
